/* dv/smsp_peer.sv */
// Behavioural SPI peer: slave for master tests, master for slave tests
`timescale 1ns/1ps
// ****************************************
// Peer model
// ****************************************
module smsp_peer (
    input wire logic is_slave_in,
    input wire logic cpol_in,
    input wire logic cpha_in,
    input wire logic lsb_in,
    input wire logic [2:0] sel_in,
    input wire logic [7:0] csn_in,
    input wire logic sck_in,
    input wire logic mosi_in,
    input wire logic miso_in,
    output logic miso_out,
    output logic sck_out,
    output logic mosi_out,
    output logic scsn_out
);
    logic [7:0] slave_tx = 8'h00;
    logic [7:0] slave_rx = 8'h00;
    logic sel_n;
    int idx = 0;
    initial begin
        miso_out = 1'b0;
        sck_out = 1'b0;
        mosi_out = 1'b0;
        scsn_out = 1'b1;
    end
    // Only the line picked by the select code answers
    assign sel_n = !is_slave_in || csn_in[sel_in];
    function automatic int pos(input int i);
        return lsb_in ? i : 7 - i;
    endfunction
    always @(sel_n) begin
        idx = 0;
        if (sel_n === 1'b1) begin
            // Released line shows no stale bit
            miso_out = !miso_out;
            slave_tx = slave_tx + 8'h11;
        end else if (sel_n === 1'b0 && !cpha_in) begin
            miso_out = slave_tx[pos(0)];
            idx = 1;
        end
    end
    always @(sck_in) begin
        if (sel_n === 1'b0) begin
            if ((sck_in != cpol_in) == !cpha_in) begin
                slave_rx = lsb_in ? {mosi_in, slave_rx[7:1]} : {slave_rx[6:0], mosi_in};
            end else if (idx < 8) begin
                miso_out = slave_tx[pos(idx)];
                idx++;
            end else begin
                miso_out = !miso_out;
            end
        end
    end
    // master frame, link clock still outside it
    task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
        sck_out = cpol_in;
        #80 scsn_out = 1'b0;
        if (!cpha_in) mosi_out = tx[pos(0)];
        #80;
        for (int i = 0; i < 8; i++) begin
            sck_out = !cpol_in;
            if (cpha_in) mosi_out = tx[pos(i)];
            else rx[pos(i)] = miso_in;
            #40 sck_out = cpol_in;
            if (cpha_in) rx[pos(i)] = miso_in;
            else if (i < 7) mosi_out = tx[pos(i + 1)];
            #40;
        end
        scsn_out = 1'b1;
        mosi_out = !mosi_out;
    endtask
endmodule

/* dv/tb_spi_master_slave_port.sv */
// Self-checking bench for the SPI master/slave port
`timescale 1ns/1ps
// ****************************************
// Bench
// ****************************************
module tb_spi_master_slave_port import smsp_pkg::*; ();
    logic clk = 0, rst = 1, mm = 1, cpol = 0, cpha = 0, lsb = 0, irq_en = 0, wake_en = 0;
    logic stdby_req = 0, cyc = 0, stb = 0, we = 0, adr = 0, cfg_n = 1, fault_n = 1;
    logic [2:0] cs = 3'h0;
    logic [7:0] wdat = 8'h00;
    logic [7:0] dat_o, csn;
    logic ack, irq, modf, stdby, wake, clk_o, clk_oe, miso_o, miso_oe, mosi_o, mosi_oe;
    logic p_miso, p_sck, p_mosi, p_scsn, clk_w, miso_w, mosi_w;
    int bad_count = 0;
    int check_count = 0;
    always #4 clk = !clk;
    // Wire levels from the core's enables; the peer drives each wire otherwise
    assign clk_w = clk_oe ? clk_o : p_sck;
    assign mosi_w = mosi_oe ? mosi_o : p_mosi;
    assign miso_w = miso_oe ? miso_o : p_miso;
    smsp_core u_dut (.CLOCK_IN(clk), .RESET_IN(rst), .MASTER_MODE_IN(mm), .CPOL_IN(cpol),
        .CPHA_IN(cpha), .LSB_FIRST_IN(lsb), .CS_SEL_IN(cs), .IRQ_EN_IN(irq_en),
        .WAKE_EN_IN(wake_en), .STDBY_REQ_IN(stdby_req), .WB_CYC_IN(cyc), .WB_STB_IN(stb),
        .WB_WE_IN(we), .WB_ADR_IN(adr), .WB_DAT_IN(wdat), .WB_DAT_OUT(dat_o), .WB_ACK_OUT(ack),
        .IRQ_OUT(irq), .MODE_FAULT_OUT(modf), .STDBY_OUT(stdby), .WAKE_OUT(wake),
        .SPI_CLK_IN(clk_w), .SPI_CLK_OUT(clk_o), .SPI_CLK_OE_OUT(clk_oe), .SPI_MISO_IN(miso_w),
        .SPI_MISO_OUT(miso_o), .SPI_MISO_OE_OUT(miso_oe), .SPI_MOSI_IN(mosi_w),
        .SPI_MOSI_OUT(mosi_o), .SPI_MOSI_OE_OUT(mosi_oe), .SPI_CSN_OUT(csn),
        .SPI_SCSN_IN(p_scsn & fault_n), .CONFIG_LOGIC_SELECT_N_IN(cfg_n));
    smsp_peer u_peer (.is_slave_in(mm), .cpol_in(cpol), .cpha_in(cpha), .lsb_in(lsb),
        .sel_in(cs), .csn_in(csn), .sck_in(clk_w), .mosi_in(mosi_w), .miso_in(miso_w),
        .miso_out(p_miso), .sck_out(p_sck), .mosi_out(p_mosi), .scsn_out(p_scsn));
    task automatic finish_test();
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        check_count++;
        if (got !== exp) begin
            bad_count++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask
    // One classic cycle, held until the acknowledge edge
    task automatic wb(input logic w, input logic a, input logic [7:0] d, output logic [7:0] q);
        int n;
        n = 0;
        @(posedge clk);
        #1 cyc = 1;
        stb = 1;
        we = w;
        adr = a;
        wdat = d;
        do begin
            @(posedge clk);
            n++;
        end while (ack !== 1'b1 && n < 300);
        q = dat_o;
        #1 cyc = 0;
        stb = 0;
        if (n >= 300) chk("ack", 8'h01, 8'h00);
    endtask
    task automatic rd(input logic a, input logic [7:0] exp, input string what);
        logic [7:0] q;
        wb(0, a, 8'h00, q);
        chk(what, exp, q);
    endtask
    // Bounded poll, slow enough for one whole byte
    task automatic wait_rx();
        logic [7:0] s;
        int n;
        n = 0;
        s = 8'h00;
        while (s[ST_RX_VALID] !== 1'b1 && n < 100) begin
            wb(0, ADR_STATUS, 8'h00, s);
            n++;
        end
    endtask
    initial begin
        #200000;
        bad_count++;
        finish_test();
    end
    initial begin
        logic [7:0] q, e;
        repeat (3) @(posedge clk);
        #1 rst = 0;
        chk("reset csn", CSN_IDLE, csn);
        chk("reset fault", 8'h00, {7'h0, modf});
        for (int m = 0; m < 8; m++) begin
            cpol = m[0];
            cpha = m[1];
            lsb = m[2];
            cs = 3'(m);
            u_peer.slave_tx = 8'hA5 ^ 8'(m);
            e = 8'h3C + 8'(m);
            wb(1, ADR_DATA, e, q);
            repeat (20) @(posedge clk);
            chk("csn", ~(8'h01 << m), csn);
            chk("master pins", 8'h06, {5'h0, clk_oe, mosi_oe, miso_oe});
            rd(ADR_STATUS, 8'h01 << ST_BUSY, "busy status");
            wait_rx();
            rd(ADR_DATA, 8'hA5 ^ 8'(m), "master rx");
            chk("peer rx", e, u_peer.slave_rx);
        end
        chk("idle sck", 8'h01, {7'h0, clk_o});
        $display("test master modes done");
        cpol = 0;
        cpha = 0;
        lsb = 0;
        cs = 3'h0;
        fault_n = 0;
        repeat (8) @(posedge clk);
        #1 fault_n = 1;
        chk("fault", 8'h01, {7'h0, modf});
        chk("irq masked", 8'h00, {7'h0, irq});
        irq_en = 1;
        #2 chk("irq", 8'h01, {7'h0, irq});
        u_peer.slave_tx = 8'h10;
        wb(1, ADR_DATA, 8'h81, q);
        wb(1, ADR_DATA, 8'h82, q);
        rd(ADR_STATUS, 8'h01 << ST_MODF | 8'h01 << ST_TX_FULL, "held status");
        wb(1, ADR_STATUS, 8'h01, q);
        #2 chk("irq cleared", 8'h00, {6'h0, irq, modf});
        repeat (300) @(posedge clk);
        rd(ADR_STATUS, 8'h01 << ST_RX_VALID, "rx status");
        rd(ADR_DATA, 8'h10, "rx first");
        rd(ADR_DATA, 8'h21, "rx second");
        chk("peer last", 8'h82, u_peer.slave_rx);
        rd(ADR_STATUS, 8'h00, "empty status");
        rd(ADR_DATA, 8'h00, "empty data");
        $display("test fault and buffer done");
        stdby_req = 1;
        #2 chk("stdby off", 8'h00, {6'h0, stdby, wake});
        wake_en = 1;
        #2 chk("stdby on", 8'h01, {7'h0, stdby});
        stdby_req = 0;
        mm = 0;
        cpol = 1;
        cpha = 1;
        lsb = 1;
        wb(1, ADR_DATA, 8'h5E, q);
        fork
            u_peer.xfer(8'hC6, e);
            begin
                #400;
                chk("slave pins", 8'h01, {5'h0, clk_oe, mosi_oe, miso_oe});
                chk("wake", 8'h01, {7'h0, wake});
            end
        join
        chk("slave tx", 8'h5E, e);
        wait_rx();
        rd(ADR_DATA, 8'hC6, "slave rx");
        chk("slave fault", 8'h00, {7'h0, modf});
        cfg_n = 0;
        u_peer.xfer(8'h3A, q);
        repeat (20) @(posedge clk);
        rd(ADR_STATUS, 8'h00, "config select");
        $display("test slave done");
        finish_test();
    end
endmodule

/* src/smsp_core.sv */
// SPI master/slave port with WISHBONE data port and slave link domain
`timescale 1ns/1ps

// ****************************************
// Three-stage synchroniser with agreement
// ****************************************
module smsp_sync (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic d_in,
    output logic q_out
);
    logic s1, s2, s3;
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            s1 <= 1'h0;
            s2 <= 1'h0;
            s3 <= 1'h0;
            q_out <= 1'h0;
        end else begin
            s1 <= d_in;
            s2 <= s1;
            s3 <= s2;
            if (s2 == s3) begin
                q_out <= s3;
            end
        end
    end
endmodule

// ****************************************
// Two-entry valid/ready buffer
// ****************************************
module smsp_fifo import smsp_pkg::*; (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic in_valid_in,
    output logic in_ready_out,
    input wire logic [DATA_W-1:0] in_data_in,
    output logic out_valid_out,
    input wire logic out_ready_in,
    output logic [DATA_W-1:0] out_data_out
);
    logic [DATA_W-1:0] mem [FIFO_DEPTH];
    logic wp, rp;
    logic [1:0] cnt;
    logic push, pop;
    assign in_ready_out = (cnt != 2'(FIFO_DEPTH));
    assign out_valid_out = (cnt != 2'h0);
    assign out_data_out = mem[rp];
    assign push = in_valid_in && in_ready_out;
    assign pop = out_valid_out && out_ready_in;
    always_ff @(posedge clk_in) begin
        if (push) begin
            mem[wp] <= in_data_in;
        end
    end
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            wp <= 1'h0;
            rp <= 1'h0;
            cnt <= 2'h0;
        end else begin
            wp <= wp ^ push;
            rp <= rp ^ pop;
            cnt <= cnt + 2'(push) - 2'(pop);
        end
    end
endmodule

// ****************************************
// Top
// ****************************************
module smsp_core import smsp_pkg::*; (
    input wire logic CLOCK_IN,
    input wire logic RESET_IN,
    input wire logic MASTER_MODE_IN,
    input wire logic CPOL_IN,
    input wire logic CPHA_IN,
    input wire logic LSB_FIRST_IN,
    input wire logic [2:0] CS_SEL_IN,
    input wire logic IRQ_EN_IN,
    input wire logic WAKE_EN_IN,
    input wire logic STDBY_REQ_IN,
    input wire logic WB_CYC_IN,
    input wire logic WB_STB_IN,
    input wire logic WB_WE_IN,
    input wire logic WB_ADR_IN,
    input wire logic [7:0] WB_DAT_IN,
    output logic [7:0] WB_DAT_OUT,
    output logic WB_ACK_OUT,
    output logic IRQ_OUT,
    output logic MODE_FAULT_OUT,
    output logic STDBY_OUT,
    output logic WAKE_OUT,
    input wire logic SPI_CLK_IN,
    output logic SPI_CLK_OUT,
    output logic SPI_CLK_OE_OUT,
    input wire logic SPI_MISO_IN,
    output logic SPI_MISO_OUT,
    output logic SPI_MISO_OE_OUT,
    input wire logic SPI_MOSI_IN,
    output logic SPI_MOSI_OUT,
    output logic SPI_MOSI_OE_OUT,
    output logic [7:0] SPI_CSN_OUT,
    input wire logic SPI_SCSN_IN,
    input wire logic CONFIG_LOGIC_SELECT_N_IN
);
    function automatic logic first_bit(input logic [7:0] w, input logic lsbf);
        first_bit = lsbf ? w[0] : w[7];
    endfunction
    function automatic logic [7:0] shift_out(input logic [7:0] w, input logic lsbf);
        shift_out = lsbf ? {1'h0, w[7:1]} : {w[6:0], 1'h0};
    endfunction
    function automatic logic [7:0] shift_in(input logic [7:0] w, input logic b,
                                            input logic lsbf);
        shift_in = lsbf ? {b, w[7:1]} : {w[6:0], b};
    endfunction

    smsp_state_t st;
    logic [3:0] div, edge_cnt;
    logic sck, mosi, modf, wb_ack, slv_loaded;
    logic [7:0] tx_sh, rx_sh, slv_tx, wb_dat;
    logic miso_s, scsn_s, done_s, done_q;
    logic txf_in_valid, txf_in_ready, txf_out_valid, txf_out_ready;
    logic rxf_in_valid, rxf_in_ready, rxf_out_valid, rxf_out_ready;
    logic [7:0] txf_out_data, rxf_in_data, rxf_out_data;
    logic wb_req, master, slv_done, modf_set, modf_clr, start, tick;
    // Link domain
    logic slv_sel_n, lk_clk;
    logic [2:0] lk_idx;
    // No system reset reaches the link clock; known start values keep the toggle crossing sane
    logic [2:0] lk_in_cnt = 3'h0;
    logic [2:0] lk_out_cnt = 3'h0;
    logic [7:0] lk_rx_sh = DATA_RST;
    logic [7:0] lk_rx_word = DATA_RST;
    logic lk_tgl = 1'h0;

    assign master = MASTER_MODE_IN;
    assign wb_req = WB_CYC_IN && WB_STB_IN && !wb_ack;

    // ****************************************
    // Pin inputs and the link done toggle into the system domain
    // ****************************************
    smsp_sync u_miso (.clk_in(CLOCK_IN), .rst_in(RESET_IN), .d_in(SPI_MISO_IN),
                      .q_out(miso_s));
    smsp_sync u_scsn (.clk_in(CLOCK_IN), .rst_in(RESET_IN), .d_in(!SPI_SCSN_IN),
                      .q_out(scsn_s));
    smsp_sync u_done (.clk_in(CLOCK_IN), .rst_in(RESET_IN), .d_in(lk_tgl),
                      .q_out(done_s));

    // ****************************************
    // Data buffers
    // ****************************************
    // double buffering
    smsp_fifo u_txf (.clk_in(CLOCK_IN), .rst_in(RESET_IN),
                     .in_valid_in(txf_in_valid), .in_ready_out(txf_in_ready),
                     .in_data_in(WB_DAT_IN), .out_valid_out(txf_out_valid),
                     .out_ready_in(txf_out_ready), .out_data_out(txf_out_data));
    smsp_fifo u_rxf (.clk_in(CLOCK_IN), .rst_in(RESET_IN),
                     .in_valid_in(rxf_in_valid), .in_ready_out(rxf_in_ready),
                     .in_data_in(rxf_in_data), .out_valid_out(rxf_out_valid),
                     .out_ready_in(rxf_out_ready), .out_data_out(rxf_out_data));

    // Master waits for a free receive slot, so a stalled reader loses nothing
    assign start = (st == SMSP_IDLE) && master && txf_out_valid && rxf_in_ready
                   && !modf && !scsn_s;
    assign slv_done = !master && (done_s != done_q);
    assign txf_out_ready = start || (!master && txf_out_valid && (slv_done || !slv_loaded));
    assign rxf_in_valid = (st == SMSP_DONE) || slv_done;
    assign rxf_in_data = master ? rx_sh : lk_rx_word;

    // ****************************************
    // WISHBONE slave
    // ****************************************
    // eight-bit bus port
    assign txf_in_valid = wb_req && WB_WE_IN && (WB_ADR_IN == ADR_DATA);
    assign rxf_out_ready = wb_req && !WB_WE_IN && (WB_ADR_IN == ADR_DATA);
    assign modf_clr = wb_req && WB_WE_IN && (WB_ADR_IN == ADR_STATUS)
                      && WB_DAT_IN[ST_MODF];
    always_ff @(posedge CLOCK_IN) begin
        if (RESET_IN) begin
            wb_ack <= 1'h0;
            wb_dat <= DATA_RST;
        end else begin
            // Writes to a full buffer stall until a slot frees
            wb_ack <= wb_req && !(txf_in_valid && !txf_in_ready);
            if (wb_req && !WB_WE_IN) begin
                if (WB_ADR_IN == ADR_STATUS) begin
                    wb_dat <= {4'h0, st != SMSP_IDLE, rxf_out_valid, !txf_in_ready, modf};
                end else begin
                    wb_dat <= rxf_out_valid ? rxf_out_data : DATA_RST;
                end
            end
        end
    end
    assign WB_ACK_OUT = wb_ack;
    assign WB_DAT_OUT = wb_dat;

    // ****************************************
    // Mode fault
    // ****************************************
    // fault when selected while master
    assign modf_set = master && scsn_s;
    always_ff @(posedge CLOCK_IN) begin
        if (RESET_IN) begin
            modf <= 1'h0;
        end else if (modf_set) begin
            modf <= 1'h1;
        end else if (modf_clr) begin
            modf <= 1'h0;
        end
    end
    assign MODE_FAULT_OUT = modf;
    assign IRQ_OUT = modf && IRQ_EN_IN;

    // ****************************************
    // Master engine
    // ****************************************
    assign tick = (div == SCK_HALF_LAST);
    always_ff @(posedge CLOCK_IN) begin
        if (RESET_IN) begin
            st <= SMSP_IDLE;
            div <= 4'h0;
            edge_cnt <= 4'h0;
            sck <= 1'h0;
            mosi <= 1'h0;
            tx_sh <= DATA_RST;
            rx_sh <= DATA_RST;
        end else begin
            unique case (st)
                SMSP_IDLE: begin
                    sck <= CPOL_IN;
                    div <= 4'h0;
                    edge_cnt <= 4'h0;
                    if (start) begin
                        st <= SMSP_RUN;
                        tx_sh <= CPHA_IN ? txf_out_data : shift_out(txf_out_data, LSB_FIRST_IN);
                        if (!CPHA_IN) begin
                            mosi <= first_bit(txf_out_data, LSB_FIRST_IN);
                        end
                    end
                end
                SMSP_RUN: begin
                    div <= tick ? 4'h0 : div + 4'h1;
                    if (modf_set) begin
                        st <= SMSP_IDLE;
                    end else if (tick) begin
                        sck <= !sck;
                        edge_cnt <= edge_cnt + 4'h1;
                        if (edge_cnt[0] == CPHA_IN) begin
                            rx_sh <= shift_in(rx_sh, miso_s, LSB_FIRST_IN);
                        end else begin
                            mosi <= first_bit(tx_sh, LSB_FIRST_IN);
                            tx_sh <= shift_out(tx_sh, LSB_FIRST_IN);
                        end
                        if (edge_cnt == EDGE_LAST) begin
                            st <= SMSP_DONE;
                        end
                    end
                end
                SMSP_DONE: begin
                    st <= SMSP_IDLE;
                end
                default: begin
                    st <= SMSP_IDLE;
                end
            endcase
        end
    end

    // ****************************************
    // Pins
    // ****************************************
    // role select
    assign SPI_CLK_OUT = sck;
    assign SPI_CLK_OE_OUT = master;
    assign SPI_MOSI_OUT = mosi;
    assign SPI_MOSI_OE_OUT = master;
    always_comb begin
        SPI_CSN_OUT = CSN_IDLE;
        if (master && st != SMSP_IDLE) begin
            SPI_CSN_OUT[CS_SEL_IN] = 1'h0;
        end
    end
    assign STDBY_OUT = WAKE_EN_IN && STDBY_REQ_IN;
    assign WAKE_OUT = WAKE_EN_IN && !master && scsn_s;

    // ****************************************
    // Slave transmit word and done crossing
    // ****************************************
    // Word is held while the link shifts it; once loaded it changes only at a byte end, but an unloaded slot takes the first word at once
    always_ff @(posedge CLOCK_IN) begin
        if (RESET_IN) begin
            done_q <= 1'h0;
            slv_tx <= DATA_RST;
            slv_loaded <= 1'h0;
        end else begin
            done_q <= done_s;
            if (!master && txf_out_ready) begin
                slv_tx <= txf_out_data;
                slv_loaded <= 1'h1;
            end else if (master) begin
                slv_loaded <= 1'h0;
            end
        end
    end

    // ****************************************
    // Slave link domain
    // ****************************************
    // selected by external master
    // config select steers away from the core
    assign slv_sel_n = SPI_SCSN_IN || !CONFIG_LOGIC_SELECT_N_IN || master;
    // Sampling edge becomes the rising edge for every mode
    assign lk_clk = SPI_CLK_IN ^ CPOL_IN ^ CPHA_IN;
    always_ff @(posedge lk_clk or posedge slv_sel_n) begin
        if (slv_sel_n) begin
            lk_in_cnt <= 3'h0;
            lk_rx_sh <= DATA_RST;
        end else begin
            lk_in_cnt <= lk_in_cnt + 3'h1;
            lk_rx_sh <= shift_in(lk_rx_sh, SPI_MOSI_IN, LSB_FIRST_IN);
        end
    end
    // Word and toggle survive deselect so the last byte still crosses
    always_ff @(posedge lk_clk) begin
        if (!slv_sel_n && lk_in_cnt == 3'h7) begin
            lk_rx_word <= shift_in(lk_rx_sh, SPI_MOSI_IN, LSB_FIRST_IN);
            lk_tgl <= !lk_tgl;
        end
    end
    always_ff @(negedge lk_clk or posedge slv_sel_n) begin
        if (slv_sel_n) begin
            lk_out_cnt <= 3'h0;
        end else begin
            lk_out_cnt <= lk_out_cnt + 3'h1;
        end
    end
    assign lk_idx = CPHA_IN ? lk_out_cnt - 3'h1 : lk_out_cnt;
    assign SPI_MISO_OUT = LSB_FIRST_IN ? slv_tx[lk_idx] : slv_tx[3'h7 - lk_idx];
    assign SPI_MISO_OE_OUT = !slv_sel_n;

    // ****************************************
    // Checks
    // ****************************************
    default clocking cb @(posedge CLOCK_IN); endclocking
    default disable iff (RESET_IN);

    sequence s_start;
        st == SMSP_IDLE ##1 st == SMSP_RUN;
    endsequence
    property p_len;
        disable iff (RESET_IN || modf_set) s_start |-> ##127 st == SMSP_RUN ##1 st == SMSP_DONE;
    endproperty
    a_len: assert property (p_len) else $error("Byte length wrong");
    property p_modf;
        modf_set |=> modf;
    endproperty
    a_modf: assert property (p_modf) else $error("Mode fault missed");
    property p_modf_hold;
        modf && !modf_clr |=> modf;
    endproperty
    a_modf_hold: assert property (p_modf_hold) else $error("Fault flag lost");
    property p_csn;
        master && st == SMSP_RUN |-> $countones(~SPI_CSN_OUT) == 1;
    endproperty
    a_csn: assert property (p_csn) else $error("Select not one-hot");
    property p_dir;
        SPI_CLK_OE_OUT == master && !(SPI_MISO_OE_OUT && SPI_MOSI_OE_OUT);
    endproperty
    a_dir: assert property (p_dir) else $error("Pin direction clash");
    property p_idle;
        st == SMSP_IDLE && $past(st) == SMSP_IDLE && !$past(RESET_IN)
            |-> sck == $past(CPOL_IN);
    endproperty
    a_idle: assert property (p_idle) else $error("Idle clock level");
    property p_wake;
        !WAKE_EN_IN |-> !STDBY_OUT && !WAKE_OUT;
    endproperty
    a_wake: assert property (p_wake) else $error("Power outputs active");
    property p_ack;
        WB_ACK_OUT |=> !WB_ACK_OUT;
    endproperty
    a_ack: assert property (p_ack) else $error("Ack too long");
    property p_push;
        st == SMSP_DONE |-> rxf_in_ready;
    endproperty
    a_push: assert property (p_push) else $error("Receive word lost");
endmodule

/* src/smsp_pkg.sv */
// Constants and types for the SPI master/slave port
// Behaviour
// - Core runs as SPI master or slave
// - Clock driven as master, input as slave
// - MISO sampled as master, driven as slave
// - MOSI driven as master, received as slave
// - Eight chip selects, one slave each
// - Mode fault sets flag and interrupt
// - Double-buffered transmit and receive data
// - Programmable clock polarity and phase
// - Selectable LSB or MSB first
// - Eight-bit WISHBONE slave data port
// - Standby and wake outputs need wake enable
package smsp_pkg;
    // ****************************************
    // Timing
    // ****************************************
    localparam int CLK_PERIOD_NS = 8;
    localparam int SCK_HALF_NS = 64;
    localparam int SCK_HALF_CYC_I = (SCK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [3:0] SCK_HALF_LAST = 4'(SCK_HALF_CYC_I - 1);
    localparam logic [3:0] EDGE_LAST = 4'hF;
    // ****************************************
    // Data path and bus map
    // ****************************************
    localparam int DATA_W = 8;
    localparam int FIFO_DEPTH = 2;
    localparam logic ADR_DATA = 1'h0;
    localparam logic ADR_STATUS = 1'h1;
    localparam int ST_MODF = 0;
    localparam int ST_TX_FULL = 1;
    localparam int ST_RX_VALID = 2;
    localparam int ST_BUSY = 3;
    localparam logic [7:0] CSN_IDLE = 8'hFF;
    localparam logic [7:0] DATA_RST = 8'h00;
    typedef enum logic [1:0] {
        SMSP_IDLE = 2'b00,
        SMSP_RUN = 2'b01,
        SMSP_DONE = 2'b10
    } smsp_state_t;
endpackage
